// ---- logic/acs_consts.svh ----
// Offsets, field positions, reset values and divider counts of the automatic serial unit
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH

// ----------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define ACS_IDX_MODE 16'hFF90
`define ACS_IDX_SSC 16'hFF91
`define ACS_IDX_INTV 16'hFF92
`define ACS_IDX_DIV 16'hFF93
`define ACS_IDX_XFER 16'hFF94
`define ACS_IDX_DATA 16'hFF95

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ACS_SSC_HALVE 6
`define ACS_SSC_STROBE 5
`define ACS_SSC_ACTIVE 0
`define ACS_MODE_EN 7
`define ACS_MODE_MASTER 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ACS_SSC_RST 8'h00
`define ACS_DIV_RST 2'h3
`define ACS_MODE_RST 8'h00

// ----------------------------------------------------------------
// Timing counts: base clock cycles per half transfer clock, and strobe gap in transfer clocks
// ----------------------------------------------------------------
`define ACS_HALF_DIV6 6'h03
`define ACS_HALF_DIV8 6'h04
`define ACS_HALF_DIV16 6'h08
`define ACS_HALF_DIV32 6'h10
`define ACS_STROBE_GAP_CLK 3'h2

`endif

// ---- logic/acs_pkg.sv ----
// Types shared by the automatic serial unit
package acs_pkg;

	// Shift engine states
	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_shift = 2'b01,
		st_gap = 2'b10
	} acs_state_t;

endpackage : acs_pkg

// ---- logic/acs_clkgen.sv ----
// Transfer clock half-period tick generator for the automatic serial unit
`timescale 1ns/100ps
`include "acs_consts.svh"
module acs_clkgen #(
	parameter int CW = 6
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	input wire logic halve,
	input wire logic [1:0] div_code,
	output logic tick_q
);

	// ----------------------------------------------------------------
	// Elaboration check
	// ----------------------------------------------------------------
	if (CW < 6) begin : g_bad_cw
		$error("acs_clkgen: CW must be at least 6");
	end

	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic [CW-1:0] half_base;
	logic [CW-1:0] half_len;
	logic hit;
	logic [CW-1:0] sp_q;
	logic seen_q;

	// Divisor code picks half of /6, /8, /16 or /32
	assign half_base = (div_code == 2'h0) ? CW'(`ACS_HALF_DIV6) :
		(div_code == 2'h1) ? CW'(`ACS_HALF_DIV8) :
		(div_code == 2'h2) ? CW'(`ACS_HALF_DIV16) : CW'(`ACS_HALF_DIV32); // R09
	// Halving the base clock doubles every half period
	assign half_len = halve ? CW'(half_base << 1) : half_base; // R05
	assign hit = run && (cnt_q == CW'(half_len - CW'(1)));
	// Restart from zero when idle so the first half period is whole
	assign cnt_d = (!run || hit) ? '0 : CW'(cnt_q + CW'(1));

	// Counter and tick register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
			tick_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tick_q <= hit;
		end
	end

	// Spacing watch between ticks, read only by the check below
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sp_q <= '0;
			seen_q <= 1'b0;
		end else begin
			sp_q <= tick_q ? '0 : CW'(sp_q + CW'(1));
			seen_q <= run && (seen_q || tick_q);
		end
	end

	property p_tick_period;
		@(posedge pclk) disable iff (!presetn)
		(tick_q && seen_q && run) |-> (sp_q == CW'(half_len - CW'(1)));
	endproperty
	a_tick_period: assert property (p_tick_period) else $error("transfer clock period wrong"); // R09

endmodule : acs_clkgen

// ---- logic/acs_top.sv ----
// Automatic serial unit: APB registers, clock selection and byte shift engine
//
// Summary of operation
// R01 - Reset clears the status/control register to zero.
// R02 - Software never writes status/control while a transfer is active.
// R03 - Bits 0 and 1 of status/control are read-only; writes ignored.
// R04 - Software changes base-clock halving only while the unit is disabled.
// R05 - Base clock is the peripheral clock, or half of it when halving set.
// R06 - Strobe drives only when enabled and in master mode.
// R07 - Strobe forces two transfer clocks between bytes, ten clocks per byte.
// R08 - Software always writes zero to status/control bit 7.
// R09 - Divisor code selects base/6, base/8, base/16 or base/32.
// R10 - Reset loads the divisor register with three, divide by 32.
// R11 - Software never writes the divisor while a transfer is active.
// R12 - Active flag stands from transfer start until its last byte ends.
`timescale 1ns/100ps
`include "acs_consts.svh"
module acs_top #(
	parameter int IW = 5,
	parameter int BW = 5
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [17:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata_q,
	output logic pready_q,
	output logic pslverr_q,
	input wire logic sck_i,
	output logic sck_o_q,
	output logic sck_oe_q,
	input wire logic si_i,
	output logic so_q,
	output logic strobe_q
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (IW < 1 || IW > 8) begin : g_bad_iw
		$error("acs_top: IW must be 1 to 8");
	end
	if (BW < 1 || BW > 8) begin : g_bad_bw
		$error("acs_top: BW must be 1 to 8");
	end

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic halve_q;
	logic stben_q;
	logic [1:0] div_q;
	logic mode_en_q;
	logic master_q;
	logic [IW-1:0] intv_q;
	logic [7:0] tx_q;
	logic [7:0] rx_q;
	logic [7:0] sh_q;
	logic [BW-1:0] left_q;
	logic [2:0] bit_q;
	logic phase_q;
	logic active_q;
	logic [IW+1:0] gap_q;
	acs_pkg::acs_state_t state_q;
	logic sck_s1_q;
	logic sck_s2_q;
	logic sck_s3_q;
	logic si_s1_q;
	logic si_s2_q;
	logic tick;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	wire [15:0] idx = paddr[17:2];
	wire aligned = (paddr[1:0] == 2'h0);
	wire sel_mode = aligned && (idx == `ACS_IDX_MODE);
	wire sel_ssc = aligned && (idx == `ACS_IDX_SSC);
	wire sel_intv = aligned && (idx == `ACS_IDX_INTV);
	wire sel_div = aligned && (idx == `ACS_IDX_DIV);
	wire sel_xfer = aligned && (idx == `ACS_IDX_XFER);
	wire sel_data = aligned && (idx == `ACS_IDX_DATA);
	wire mapped = sel_mode || sel_ssc || sel_intv || sel_div || sel_xfer || sel_data;
	// Access phase seen: answer one cycle later
	wire acc = psel && penable && !pready_q;
	// Completion edge: the only edge at which a write lands
	wire wr_fire = psel && penable && pready_q && pwrite && mapped;
	wire idle = (state_q == acs_pkg::st_idle);
	wire start = wr_fire && sel_xfer && mode_en_q && idle && !active_q;

	// Read views; status/control busy/error fields and bit 7 read as zero
	wire [7:0] ssc_rd = {1'b0, halve_q, stben_q, 4'h0, active_q};
	wire [7:0] mode_rd = {mode_en_q, 6'h00, master_q};
	wire [7:0] rd_byte = sel_ssc ? ssc_rd :
		sel_mode ? mode_rd :
		sel_intv ? 8'(intv_q) :
		sel_div ? {6'h00, div_q} :
		sel_xfer ? 8'(left_q) :
		sel_data ? rx_q : 8'h00;

	// ----------------------------------------------------------------
	// APB answer
	// ----------------------------------------------------------------
	// One wait state so every output stays a flip-flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end else begin
			pready_q <= acc;
			pslverr_q <= acc && !mapped;
			prdata_q <= acc ? {24'h000000, rd_byte} : prdata_q;
		end
	end

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------
	// Status/control keeps only bits 6 and 5; bits 0 and 1 ignore writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			halve_q <= 1'(`ACS_SSC_RST >> `ACS_SSC_HALVE); // R01
			stben_q <= 1'b0; // R01
		end else if (wr_fire && sel_ssc) begin
			halve_q <= pwdata[`ACS_SSC_HALVE]; // R03
			stben_q <= pwdata[`ACS_SSC_STROBE]; // R03
		end
	end

	// Divisor, mode, interval and transmit data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= `ACS_DIV_RST; // R10
			mode_en_q <= 1'b0;
			master_q <= 1'b0;
			intv_q <= '0;
			tx_q <= 8'h00;
		end else if (wr_fire) begin
			div_q <= sel_div ? pwdata[1:0] : div_q;
			mode_en_q <= sel_mode ? pwdata[`ACS_MODE_EN] : mode_en_q;
			master_q <= sel_mode ? pwdata[`ACS_MODE_MASTER] : master_q;
			intv_q <= sel_intv ? pwdata[IW-1:0] : intv_q;
			tx_q <= sel_data ? pwdata[7:0] : tx_q;
		end
	end

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	// Slave clock and data come from outside; two flops before use
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sck_s1_q <= 1'b1;
			sck_s2_q <= 1'b1;
			sck_s3_q <= 1'b1;
			si_s1_q <= 1'b0;
			si_s2_q <= 1'b0;
		end else begin
			sck_s1_q <= sck_i;
			sck_s2_q <= sck_s1_q;
			sck_s3_q <= sck_s2_q;
			si_s1_q <= si_i;
			si_s2_q <= si_s1_q;
		end
	end

	// ----------------------------------------------------------------
	// Transfer clock source
	// ----------------------------------------------------------------
	acs_clkgen #(
		.CW(6)
	) u_clkgen (
		.pclk(pclk),
		.presetn(presetn),
		.run(master_q && !idle),
		.halve(halve_q),
		.div_code(div_q),
		.tick_q(tick)
	);

	// ----------------------------------------------------------------
	// Shift engine
	// ----------------------------------------------------------------
	// Master paces on own ticks, slave on edges of the far clock
	wire ev_fall = master_q ? (tick && !phase_q) : (!sck_s2_q && sck_s3_q);
	wire ev_rise = master_q ? (tick && phase_q) : (sck_s2_q && !sck_s3_q);
	wire byte_end = (state_q == acs_pkg::st_shift) && ev_rise && (bit_q == 3'h7);
	wire [7:0] sh_in = {sh_q[6:0], si_s2_q};
	// Gap in half ticks; strobe overrides the interval
	wire [IW+1:0] gap_len = stben_q ? (IW+2)'({`ACS_STROBE_GAP_CLK, 1'b0}) :
		(IW+2)'({intv_q, 1'b0}); // R07
	wire use_gap = master_q && (gap_len != '0);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= acs_pkg::st_idle;
			active_q <= 1'b0;
			sh_q <= 8'h00;
			rx_q <= 8'h00;
			left_q <= '0;
			bit_q <= 3'h0;
			phase_q <= 1'b0;
			gap_q <= '0;
			sck_o_q <= 1'b1;
			so_q <= 1'b0;
			strobe_q <= 1'b0;
		end else begin
			case (state_q)
				acs_pkg::st_idle: begin
					if (start) begin
						state_q <= acs_pkg::st_shift;
						active_q <= 1'b1; // R12
						sh_q <= tx_q;
						left_q <= pwdata[BW-1:0];
						bit_q <= 3'h0;
						phase_q <= 1'b0;
					end
				end
				acs_pkg::st_shift: begin
					if (ev_fall) begin
						sck_o_q <= 1'b0;
						so_q <= sh_q[7];
						phase_q <= 1'b1;
					end
					if (ev_rise) begin
						sck_o_q <= 1'b1;
						phase_q <= 1'b0;
						sh_q <= sh_in;
						bit_q <= 3'(bit_q + 3'h1);
					end
					if (byte_end) begin
						rx_q <= sh_in;
						if (left_q == '0) begin
							state_q <= acs_pkg::st_idle;
							active_q <= 1'b0; // R12
						end else begin
							left_q <= BW'(left_q - BW'(1));
							sh_q <= tx_q;
							if (use_gap) begin
								state_q <= acs_pkg::st_gap;
								gap_q <= gap_len; // R07
								strobe_q <= stben_q && master_q; // R06
							end
						end
					end
				end
				acs_pkg::st_gap: begin
					// Strobe covers the first of the two gap clocks
					if (tick) begin
						gap_q <= (IW+2)'(gap_q - (IW+2)'(1));
						if (gap_q <= (IW+2)'(3)) begin
							strobe_q <= 1'b0; // R07
						end
						if (gap_q == (IW+2)'(1)) begin
							state_q <= acs_pkg::st_shift;
						end
					end
				end
				default: begin
					state_q <= acs_pkg::st_idle;
					active_q <= 1'b0;
				end
			endcase
		end
	end

	// Clock pin drive: master owns the line only while enabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sck_oe_q <= 1'b0;
		end else begin
			sck_oe_q <= master_q && mode_en_q;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_gap_entry;
		byte_end && (left_q != '0) && master_q && stben_q;
	endsequence

	sequence s_last_byte;
		byte_end && (left_q == '0);
	endsequence

	property p_ssc_reset;
		@(posedge pclk) $rose(presetn) |-> (ssc_rd == `ACS_SSC_RST);
	endproperty
	a_ssc_reset: assert property (p_ssc_reset) else $error("status/control not zero after reset"); // R01

	property p_div_reset;
		@(posedge pclk) $rose(presetn) |-> (div_q == `ACS_DIV_RST);
	endproperty
	a_div_reset: assert property (p_div_reset) else $error("divisor not three after reset"); // R10

	property p_ro_bits;
		@(posedge pclk) disable iff (!presetn)
		(wr_fire && sel_ssc && idle) |=> (ssc_rd[1:0] == 2'h0 && halve_q == $past(pwdata[`ACS_SSC_HALVE]) &&
			stben_q == $past(pwdata[`ACS_SSC_STROBE]));
	endproperty
	a_ro_bits: assert property (p_ro_bits) else $error("read-only status bits took a write"); // R03

	property p_strobe_master;
		@(posedge pclk) disable iff (!presetn)
		strobe_q |-> (master_q && stben_q && state_q == acs_pkg::st_gap);
	endproperty
	a_strobe_master: assert property (p_strobe_master) else $error("strobe driven outside master gap"); // R06

	property p_strobe_gap;
		@(posedge pclk) disable iff (!presetn)
		s_gap_entry |=> (state_q == acs_pkg::st_gap && gap_q == (IW+2)'(4) && strobe_q);
	endproperty
	a_strobe_gap: assert property (p_strobe_gap) else $error("strobe gap not two clocks"); // R07

	property p_active_busy;
		@(posedge pclk) disable iff (!presetn)
		(state_q != acs_pkg::st_idle) |-> active_q;
	endproperty
	a_active_busy: assert property (p_active_busy) else $error("active flag low during transfer"); // R12

	property p_active_end;
		@(posedge pclk) disable iff (!presetn)
		s_last_byte |=> (!active_q && state_q == acs_pkg::st_idle);
	endproperty
	a_active_end: assert property (p_active_end) else $error("active flag not cleared at end"); // R12

endmodule : acs_top

// ---- verification/acs_link_dev.sv ----
// Behavioural serial device on the far end of the three-wire link
`timescale 1ns/100ps
module acs_link_dev #(
	parameter logic [7:0] DEV_BYTE = 8'h3C
) (
	input wire logic lk,
	input wire logic act,
	input wire logic so,
	output logic si,
	output logic [7:0] got
);
	logic [7:0] tx_q = DEV_BYTE;
	logic bit_v = 1'b0;
	// Next bit on the falling clock, MSB first; rotating repeats the byte
	always @(negedge lk) begin
		if (act) begin
			bit_v <= tx_q[7];
			tx_q <= {tx_q[6:0], tx_q[7]};
		end
	end
	// Released line shows the inverse, so a stale bit never reads as good
	assign si = act ? bit_v : ~bit_v;
	// Capture the unit's data on the rising clock
	always @(posedge lk) begin
		if (act) begin
			got <= {got[6:0], so};
		end
	end
	initial begin
		got = 8'h00;
	end
endmodule : acs_link_dev

// ---- verification/tb.sv ----
// Self-checking bench of the automatic serial unit
`timescale 1ns/100ps
`include "acs_consts.svh"
module tb;
	typedef struct packed {logic [1:0] code; logic halve; logic [7:0] tx;} acs_row_t;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic sck_i = 1'b1;
	logic slv = 1'b0;
	logic lk_q = 1'b1;
	logic [17:0] paddr = 18'h00000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata_q, rd_v;
	logic pready_q, pslverr_q, sck_o_q, sck_oe_q, si_i, so_q, strobe_q, err_v;
	logic [7:0] dev_got;
	int n_fail = 0;
	int checks_done = 0;
	int cyc = 0;
	int stb_n = 0;
	int oe_n = 0;
	int s0, o0;
	int falls[$];
	int base_h[4] = '{3, 4, 8, 16};
	acs_row_t rows[8] = '{'{2'h0, 1'b0, 8'hA5}, '{2'h1, 1'b0, 8'h81}, '{2'h2, 1'b0, 8'h7E},
		'{2'h3, 1'b0, 8'h01}, '{2'h0, 1'b1, 8'hC3}, '{2'h1, 1'b1, 8'h5A}, '{2'h2, 1'b1, 8'hFF},
		'{2'h3, 1'b1, 8'h00}};
	wire lk = sck_oe_q ? sck_o_q : sck_i;

	always #4 pclk = ~pclk;

	acs_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
		.sck_i(sck_i), .sck_o_q(sck_o_q), .sck_oe_q(sck_oe_q), .si_i(si_i), .so_q(so_q), .strobe_q(strobe_q));
	acs_link_dev dev_u (.lk(lk), .act(sck_oe_q | slv), .so(so_q), .si(si_i), .got(dev_got));

	// Link monitor: clock fall times and strobe/drive counts in pclk cycles
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		lk_q <= lk;
		if (lk_q && !lk) falls.push_back(cyc);
		if (strobe_q === 1'b1) stb_n <= stb_n + 1;
		if (sck_oe_q === 1'b1 && slv) oe_n <= oe_n + 1;
	end

	// --------------------
	// Shared tasks
	// --------------------
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// One APB transfer; request held until pready is sampled high
	task apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait that never sees pready
		do begin
			@(posedge pclk);
		end while (pready_q !== 1'b1);
		rd_v = prdata_q;
		err_v = pslverr_q;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Unit switched off first, so the halving bit only changes while disabled
	task cfg(input logic [7:0] ssc, input logic [7:0] div, input logic [7:0] intv, input logic [7:0] mode);
		apb(1'b1, `ACS_IDX_MODE, 8'h00);
		apb(1'b1, `ACS_IDX_SSC, ssc);
		apb(1'b1, `ACS_IDX_DIV, div);
		apb(1'b1, `ACS_IDX_INTV, intv);
		apb(1'b1, `ACS_IDX_MODE, mode);
	endtask : cfg

	// Start nb+1 bytes, clock eight bits in slave mode, wait for the unit to go idle
	task xfer(input logic [7:0] nb);
		int n;
		falls.delete();
		apb(1'b1, `ACS_IDX_XFER, nb);
		apb(1'b0, `ACS_IDX_SSC, 8'h00);
		chk("active", rd_v[0], 1'b1);
		if (slv) repeat (16) begin
			repeat (8) @(posedge pclk);
			sck_i <= ~sck_i;
		end
		n = 0;
		while (rd_v[0] !== 1'b0 && n < 2000) begin
			apb(1'b0, `ACS_IDX_SSC, 8'h00);
			n++;
		end
		chk("idle", rd_v[0], 1'b0);
	endtask : xfer

	task test_done();
		$display("Checks %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : test_done

	// --------------------
	// Main sequence
	// --------------------
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `ACS_IDX_SSC, 8'h00);
		chk("ssc_reset", rd_v, 32'h00000000);
		apb(1'b0, `ACS_IDX_DIV, 8'h00);
		chk("div_reset", rd_v, 32'h00000003);
		chk("mapped_ok", err_v, 1'b0);
		apb(1'b1, `ACS_IDX_SSC, 8'h67);
		apb(1'b0, `ACS_IDX_SSC, 8'h00);
		chk("ssc_readonly", rd_v, 32'h00000060);
		apb(1'b0, 16'hFF9F, 8'h00);
		chk("unmapped", err_v, 1'b1);
		// Every divisor code with and without halving
		foreach (rows[i]) begin
			cfg({1'b0, rows[i].halve, 6'h00}, {6'h00, rows[i].code}, 8'h00, 8'h81);
			apb(1'b1, `ACS_IDX_DATA, rows[i].tx);
			xfer(8'h00);
			chk("tclk", falls[1] - falls[0], 2 * (base_h[rows[i].code] << rows[i].halve));
			chk("so_byte", dev_got, rows[i].tx);
			apb(1'b0, `ACS_IDX_DATA, 8'h00);
			chk("rx_byte", rd_v, 32'h0000003C);
		end
		// Byte spacing with strobe (interval ignored) and without
		for (int k = 0; k < 3; k++) begin
			cfg(k < 2 ? 8'h20 : 8'h00, 8'h00, k == 1 ? 8'h05 : 8'h00, 8'h81);
			s0 = stb_n;
			xfer(8'h01);
			chk("byte_span", falls[8] - falls[0], k < 2 ? 60 : 48);
			chk("strobe_len", stb_n - s0, k < 2 ? 6 : 0);
		end
		// Slave mode: strobe enable must have no effect
		slv = 1'b1;
		cfg(8'h20, 8'h00, 8'h00, 8'h80);
		apb(1'b1, `ACS_IDX_DATA, 8'h5A);
		s0 = stb_n;
		o0 = oe_n;
		xfer(8'h00);
		chk("slave_strobe", stb_n - s0, 0);
		chk("slave_drive", oe_n - o0, 0);
		chk("slave_byte", dev_got, 8'h5A);
		slv = 1'b0;
		// Reset in mid-transfer: registers, flag and pins return to reset values
		cfg(8'h40, 8'h01, 8'h00, 8'h81);
		apb(1'b1, `ACS_IDX_XFER, 8'h03);
		repeat (20) @(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		chk("oe_reset", sck_oe_q, 1'b0);
		chk("sck_reset", sck_o_q, 1'b1);
		chk("strobe_reset", strobe_q, 1'b0);
		apb(1'b0, `ACS_IDX_SSC, 8'h00);
		chk("ssc_mid_reset", rd_v, 32'h00000000);
		apb(1'b0, `ACS_IDX_DIV, 8'h00);
		chk("div_mid_reset", rd_v, 32'h00000003);
		apb(1'b0, `ACS_IDX_XFER, 8'h00);
		chk("left_mid_reset", rd_v, 32'h00000000);
		test_done();
	end

	// Watchdog well beyond the expected run length
	initial begin
		#640000;
		n_fail++;
		test_done();
	end
endmodule : tb
